// [vsq_config_regs.sv]
`timescale 1ns/1ps
module vsq_config_regs #(
	parameter int LINE_LEN_W  = vsq_pkg::LINE_LEN_W,
	parameter int FINAL_LEN_W = vsq_pkg::FINAL_LEN_W
) (
	// clock and reset
	input  wire logic                         i_ref_clk,
	input  wire logic                         i_sys_rst,
	// apb slave
	input  wire logic                         i_psel,
	input  wire logic                         i_penable,
	input  wire logic                         i_pwrite,
	input  wire logic [7:0]                   i_paddr,
	input  wire logic [31:0]                  i_pwdata,
	output logic      [31:0]                  o_prdata,
	output logic                              o_pready,
	output logic                              o_pslverr,
	// sequence engine status
	input  wire logic                         i_seq_change_update,
	input  wire logic                         i_line_is_odd,
	input  wire logic [3:0]                   i_last_repetition,
	input  wire logic [4*FINAL_LEN_W-1:0]     i_pattern_len_grp,
	// active configuration
	output logic      [1:0]                   o_horiz_blank_mode_sel,
	output logic                              o_horiz_blank_normal,
	output logic                              o_horiz_blank_mode1,
	output logic                              o_substrate_clk_mask_en,
	output logic      [LINE_LEN_W-1:0]        o_line_len_even,
	output logic      [LINE_LEN_W-1:0]        o_line_len_odd,
	output logic      [LINE_LEN_W-1:0]        o_line_len_cur,
	output logic      [23:0]                  o_gate_toggle_pair_sel,
	output logic      [23:0]                  o_vout_start_polarity,
	output logic      [47:0]                  o_vout_group_onehot,
	output logic      [4*FINAL_LEN_W-1:0]     o_group_len_eff
);

	//--------------------------------------------------------------------------
	// elaboration checks
	//--------------------------------------------------------------------------
	if (LINE_LEN_W < 1 || LINE_LEN_W > 32 || FINAL_LEN_W < 1 || 2*FINAL_LEN_W > 32)
	begin : g_bad_width
		$error("vsq_config_regs: field widths do not fit a 32-bit register");
	end

	// the upper final length sits at a fixed bit, so the lower field must end just below it
	if (FINAL_LEN_W != vsq_pkg::HI_HALF_LSB)
	begin : g_bad_split
		$error("vsq_config_regs: final length width must match the upper field position");
	end

	//--------------------------------------------------------------------------
	// apb decode
	//--------------------------------------------------------------------------
	localparam int FIN_HI   = vsq_pkg::HI_HALF_LSB;
	localparam int ADDR_LSB = 2;    // word aligned, byte lanes ignored
	localparam int ADDR_MSB = 7;
	localparam int BLANK_W  = 2;

	logic [31:0] seq_ctrl_q;
	logic [31:0] len_even_q;
	logic [31:0] len_odd_q;
	logic [31:0] toggle_q;
	logic [31:0] final_ab_q;
	logic [31:0] final_cd_q;
	logic [31:0] polarity_q;
	logic [31:0] group_q;
	logic        pending_q;

	wire [5:0] reg_idx  = i_paddr[ADDR_MSB:ADDR_LSB];
	wire       access   = i_psel & i_penable;
	wire       wr_en    = access & i_pwrite;
	wire       hit_ctrl = (reg_idx == vsq_pkg::IDX_SEQ_CTRL);
	wire       hit_even = (reg_idx == vsq_pkg::IDX_LEN_EVEN);
	wire       hit_odd  = (reg_idx == vsq_pkg::IDX_LEN_ODD);
	wire       hit_tog  = (reg_idx == vsq_pkg::IDX_TOGGLE_SEL);
	wire       hit_fab  = (reg_idx == vsq_pkg::IDX_FINAL_AB);
	wire       hit_fcd  = (reg_idx == vsq_pkg::IDX_FINAL_CD);
	wire       hit_pol  = (reg_idx == vsq_pkg::IDX_POLARITY);
	wire       hit_grp  = (reg_idx == vsq_pkg::IDX_GROUP_LOW);
	wire       hit_stat = (reg_idx == vsq_pkg::IDX_STATUS);
	wire       mapped   = hit_ctrl | hit_even | hit_odd | hit_tog | hit_fab | hit_fcd
	                    | hit_pol | hit_grp | hit_stat;
	wire       wr_cfg   = wr_en & mapped & ~hit_stat;

	// one strobe per staging register keeps each write process short
	wire       we_ctrl  = wr_en & hit_ctrl;
	wire       we_even  = wr_en & hit_even;
	wire       we_odd   = wr_en & hit_odd;
	wire       we_tog   = wr_en & hit_tog;
	wire       we_fab   = wr_en & hit_fab;
	wire       we_fcd   = wr_en & hit_fcd;
	wire       we_pol   = wr_en & hit_pol;
	wire       we_grp   = wr_en & hit_grp;

	// field masks so unimplemented bits read back as zero
	wire [31:0] mask_ctrl  = (32'h1 << vsq_pkg::SEQ_CTRL_W) - 32'h1;
	wire [31:0] mask_line  = (32'h1 << LINE_LEN_W) - 32'h1;
	wire [31:0] mask_vout  = (32'h1 << vsq_pkg::VOUT_W) - 32'h1;
	wire [31:0] mask_final = (32'h1 << (2*FINAL_LEN_W)) - 32'h1;

	// zero wait state slave; unmapped addresses answer with an error
	assign o_pready  = 1'b1;
	assign o_pslverr = access & ~mapped;

	// read mux; status shows an update armed but not yet taken
	wire [31:0] rd_mux = hit_ctrl ? seq_ctrl_q
	                   : hit_even ? len_even_q
	                   : hit_odd  ? len_odd_q
	                   : hit_tog  ? toggle_q
	                   : hit_fab  ? final_ab_q
	                   : hit_fcd  ? final_cd_q
	                   : hit_pol  ? polarity_q
	                   : hit_grp  ? group_q
	                   : hit_stat ? {31'h0000_0000, pending_q}
	                   : 32'h0000_0000;

	// read data is caught at the end of the setup cycle and stands through the access
	// phase: the bus keeps zero wait states while the data output comes from a flop
	logic [31:0] rdata_q;
	wire         rd_setup = i_psel & ~i_penable & ~i_pwrite;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			rdata_q <= 32'h0000_0000;
		else if (rd_setup)
			rdata_q <= rd_mux;
	end

	assign o_prdata = rdata_q;

	//--------------------------------------------------------------------------
	// staging registers written by software
	//--------------------------------------------------------------------------
	// test bits and reserved mode codes are stored as written; software keeps them legal
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			seq_ctrl_q <= vsq_pkg::REG_RESET;
		else if (we_ctrl)
			seq_ctrl_q <= i_pwdata & mask_ctrl;
	end

	// even line length, only the length field is kept
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			len_even_q <= vsq_pkg::REG_RESET;
		else if (we_even)
			len_even_q <= i_pwdata & mask_line;
	end

	// odd line length, only the length field is kept
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			len_odd_q <= vsq_pkg::REG_RESET;
		else if (we_odd)
			len_odd_q <= i_pwdata & mask_line;
	end

	// toggle pair select, one bit per vertical output
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			toggle_q <= vsq_pkg::REG_RESET;
		else if (we_tog)
			toggle_q <= i_pwdata & mask_vout;
	end

	// final lengths for groups a and b
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			final_ab_q <= vsq_pkg::REG_RESET;
		else if (we_fab)
			final_ab_q <= i_pwdata & mask_final;
	end

	// final lengths for groups c and d
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			final_cd_q <= vsq_pkg::REG_RESET;
		else if (we_fcd)
			final_cd_q <= i_pwdata & mask_final;
	end

	// start polarity, one bit per vertical output
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			polarity_q <= vsq_pkg::REG_RESET;
		else if (we_pol)
			polarity_q <= i_pwdata & mask_vout;
	end

	// group codes for the first twelve outputs
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			group_q <= vsq_pkg::REG_RESET;
		else if (we_grp)
			group_q <= i_pwdata & mask_vout;
	end

	// pending flag: a write in the update cycle keeps it set, so set wins
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			pending_q <= 1'b0;
		else if (wr_cfg)
			pending_q <= 1'b1;
		else if (i_seq_change_update)
			pending_q <= 1'b0;
	end

	//--------------------------------------------------------------------------
	// active copies, taken on the sequence change update pulse
	//--------------------------------------------------------------------------
	// changes land only at the update so the engine never sees a half-written set
	logic [31:0] act_ctrl_q;
	logic [31:0] act_even_q;
	logic [31:0] act_odd_q;
	logic [31:0] act_tog_q;
	logic [31:0] act_fab_q;
	logic [31:0] act_fcd_q;
	logic [31:0] act_pol_q;
	logic [31:0] act_grp_q;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			act_ctrl_q <= vsq_pkg::REG_RESET;
			act_even_q <= vsq_pkg::REG_RESET;
			act_odd_q  <= vsq_pkg::REG_RESET;
			act_tog_q  <= vsq_pkg::REG_RESET;
			act_fab_q  <= vsq_pkg::REG_RESET;
			act_fcd_q  <= vsq_pkg::REG_RESET;
			act_pol_q  <= vsq_pkg::REG_RESET;
			act_grp_q  <= vsq_pkg::REG_RESET;
		end
		else if (i_seq_change_update)
		begin
			act_ctrl_q <= seq_ctrl_q;
			act_even_q <= len_even_q;
			act_odd_q  <= len_odd_q;
			act_tog_q  <= toggle_q;
			act_fab_q  <= final_ab_q;
			act_fcd_q  <= final_cd_q;
			act_pol_q  <= polarity_q;
			act_grp_q  <= group_q;
		end
	end

	//--------------------------------------------------------------------------
	// decoded configuration
	//--------------------------------------------------------------------------
	wire [1:0] blank_code = act_ctrl_q[vsq_pkg::BLANK_MODE_LSB +: BLANK_W];
	wire [3:0] final_en   = act_ctrl_q[vsq_pkg::FINAL_EN_LSB +: vsq_pkg::NUM_GROUPS];
	wire [1:0] stage_code = seq_ctrl_q[vsq_pkg::BLANK_MODE_LSB +: BLANK_W];

	// mode decodes are flopped beside the active copy so both move on one edge;
	// after reset the code reads 00, so normal operation reads as selected
	logic blank_normal_q;
	logic blank_mode1_q;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			blank_normal_q <= 1'b1;
			blank_mode1_q  <= 1'b0;
		end
		else if (i_seq_change_update)
		begin
			blank_normal_q <= (stage_code == vsq_pkg::BLANK_NORMAL);
			blank_mode1_q  <= (stage_code == vsq_pkg::BLANK_MODE1);
		end
	end

	assign o_horiz_blank_mode_sel  = blank_code;
	assign o_horiz_blank_normal    = blank_normal_q;
	assign o_horiz_blank_mode1     = blank_mode1_q;
	assign o_substrate_clk_mask_en = act_ctrl_q[vsq_pkg::SUB_MASK_BIT];
	assign o_line_len_even         = act_even_q[LINE_LEN_W-1:0];
	assign o_line_len_odd          = act_odd_q[LINE_LEN_W-1:0];
	// zero picks toggles 1/2, one picks toggles 3/4
	assign o_gate_toggle_pair_sel  = act_tog_q[vsq_pkg::VOUT_W-1:0];
	// one starts the output high
	assign o_vout_start_polarity   = act_pol_q[vsq_pkg::VOUT_W-1:0];

	// final lengths: A,B from one register and C,D from the next
	wire [4*FINAL_LEN_W-1:0] final_len = {
		act_fcd_q[FIN_HI +: FINAL_LEN_W], act_fcd_q[FINAL_LEN_W-1:0],
		act_fab_q[FIN_HI +: FINAL_LEN_W], act_fab_q[FINAL_LEN_W-1:0]
	};

	//--------------------------------------------------------------------------
	// registered outputs computed from engine state and the active configuration
	//--------------------------------------------------------------------------
	logic [LINE_LEN_W-1:0]    line_cur_q;
	logic [4*FINAL_LEN_W-1:0] len_eff_q;
	logic [47:0]              grp_onehot_q;
	logic [4*FINAL_LEN_W-1:0] len_eff_d;
	logic [47:0]              grp_onehot_d;

	genvar g;
	generate
		// final length only in the last repetition and only if enabled
		for (g = 0; g < vsq_pkg::NUM_GROUPS; g++)
		begin : g_group
			assign len_eff_d[g*FINAL_LEN_W +: FINAL_LEN_W] =
				(final_en[g] & i_last_repetition[g])
				? final_len[g*FINAL_LEN_W +: FINAL_LEN_W]
				: i_pattern_len_grp[g*FINAL_LEN_W +: FINAL_LEN_W];
		end
		// 2-bit code per output, one-hot as {D,C,B,A}
		for (g = 0; g < vsq_pkg::GRP_VOUTS; g++)
		begin : g_vout
			wire [1:0] code = act_grp_q[g*vsq_pkg::GRP_CODE_W +: vsq_pkg::GRP_CODE_W];
			assign grp_onehot_d[g*vsq_pkg::NUM_GROUPS +: vsq_pkg::NUM_GROUPS] = 4'h1 << code;
		end
	endgenerate

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			line_cur_q   <= '0;
			len_eff_q    <= '0;
			grp_onehot_q <= '0;
		end
		else
		begin
			line_cur_q   <= i_line_is_odd ? o_line_len_odd : o_line_len_even;
			len_eff_q    <= len_eff_d;
			grp_onehot_q <= grp_onehot_d;
		end
	end

	assign o_line_len_cur      = line_cur_q;
	assign o_group_len_eff     = len_eff_q;
	assign o_vout_group_onehot = grp_onehot_q;

endmodule : vsq_config_regs

// [vsq_pkg.sv]
//------------------------------------------------------------------------------
// vertical sequence configuration constants
//------------------------------------------------------------------------------
package vsq_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_SEQ_CTRL   = 6'h00;
	localparam logic [5:0] IDX_LEN_EVEN   = 6'h01;
	localparam logic [5:0] IDX_LEN_ODD    = 6'h02;
	localparam logic [5:0] IDX_TOGGLE_SEL = 6'h03;
	localparam logic [5:0] IDX_FINAL_AB   = 6'h04;
	localparam logic [5:0] IDX_FINAL_CD   = 6'h05;
	localparam logic [5:0] IDX_POLARITY   = 6'h06;
	localparam logic [5:0] IDX_GROUP_LOW  = 6'h07;
	localparam logic [5:0] IDX_STATUS     = 6'h1F;

	// sequence control field positions
	localparam int FINAL_EN_LSB  = 16;
	localparam int BLANK_MODE_LSB = 20;
	localparam int TEST_LSB      = 22;
	localparam int SUB_MASK_BIT  = 24;
	localparam int SEQ_CTRL_W    = 25;

	// field widths and positions of shared registers
	localparam int LINE_LEN_W    = 14;
	localparam int FINAL_LEN_W   = 13;
	localparam int HI_HALF_LSB   = 13;
	localparam int VOUT_W        = 24;
	localparam int GRP_VOUTS     = 12;
	localparam int GRP_CODE_W    = 2;
	localparam int NUM_GROUPS    = 4;

	// blanking mode codes
	localparam logic [1:0] BLANK_NORMAL = 2'h0;
	localparam logic [1:0] BLANK_MODE1  = 2'h1;

	// reset value; documented defaults are undefined so zero is used
	localparam logic [31:0] REG_RESET = 32'h0000_0000;

endpackage : vsq_pkg

// [vsq_config_regs_checker.sv]
`timescale 1ns/1ps
module vsq_config_regs_checker #(
	parameter int LINE_LEN_W  = 14,
	parameter int FINAL_LEN_W = 13
) (
	// clock, reset, bus and sequence engine status
	input wire logic                     i_ref_clk,
	input wire logic                     i_sys_rst,
	input wire logic                     i_psel,
	input wire logic                     i_penable,
	input wire logic                     i_seq_change_update,
	input wire logic                     i_line_is_odd,
	input wire logic [3:0]               i_last_repetition,
	input wire logic [4*FINAL_LEN_W-1:0] i_pattern_len_grp,
	// configuration outputs
	input wire logic                     o_pslverr,
	input wire logic [1:0]               o_horiz_blank_mode_sel,
	input wire logic                     o_horiz_blank_normal,
	input wire logic                     o_horiz_blank_mode1,
	input wire logic                     o_substrate_clk_mask_en,
	input wire logic [LINE_LEN_W-1:0]    o_line_len_even,
	input wire logic [LINE_LEN_W-1:0]    o_line_len_odd,
	input wire logic [LINE_LEN_W-1:0]    o_line_len_cur,
	input wire logic [47:0]              o_vout_group_onehot,
	input wire logic [4*FINAL_LEN_W-1:0] o_group_len_eff
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	// each of the first twelve outputs owns exactly one group, so a bad code cannot silence it
	logic oh_ok;
	always_comb
	begin
		oh_ok = 1'b1;
		for (int k = 0; k < 12; k++)
			oh_ok &= $onehot(o_vout_group_onehot[4*k +: 4]);
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	blank_normal_a: assert property (o_horiz_blank_normal == (o_horiz_blank_mode_sel == 2'h0))
		else $error("blank normal decode wrong");
	blank_mode1_a: assert property (o_horiz_blank_mode1 == (o_horiz_blank_mode_sel == 2'h1))
		else $error("blank mode1 decode wrong");
	even_cur_a: assert property (!$past(i_sys_rst) && !$past(i_line_is_odd)
		|-> o_line_len_cur == $past(o_line_len_even)) else $error("even length not used");
	odd_cur_a: assert property (!$past(i_sys_rst) && $past(i_line_is_odd)
		|-> o_line_len_cur == $past(o_line_len_odd)) else $error("odd length not used");
	len_norm_a: assert property (!$past(i_sys_rst) && !$past(i_last_repetition[0])
		|-> o_group_len_eff[12:0] == $past(i_pattern_len_grp[12:0])) else $error("group a length");
	len_norm_d_a: assert property (!$past(i_sys_rst) && !$past(i_last_repetition[3])
		|-> o_group_len_eff[51:39] == $past(i_pattern_len_grp[51:39])) else $error("group d length");
	group_onehot_a: assert property (!$past(i_sys_rst) |-> oh_ok)
		else $error("group map not one-hot");
	mask_hold_a: assert property (!$past(i_sys_rst) && !$past(i_seq_change_update)
		|-> $stable(o_substrate_clk_mask_en)) else $error("mask changed without update");
	len_hold_a: assert property (!$past(i_sys_rst) && !$past(i_seq_change_update)
		|-> $stable(o_line_len_even) && $stable(o_line_len_odd)) else $error("length changed");
	cover property (i_psel && i_penable && o_pslverr);
	cover property (i_seq_change_update);
	cover property (o_horiz_blank_mode1);
endmodule : vsq_config_regs_checker

bind vsq_config_regs vsq_config_regs_checker #(.LINE_LEN_W(LINE_LEN_W), .FINAL_LEN_W(FINAL_LEN_W))
	chk_i (.i_ref_clk, .i_sys_rst, .i_psel, .i_penable, .i_seq_change_update, .i_line_is_odd,
	.i_last_repetition, .i_pattern_len_grp, .o_pslverr, .o_horiz_blank_mode_sel,
	.o_horiz_blank_normal, .o_horiz_blank_mode1, .o_substrate_clk_mask_en, .o_line_len_even,
	.o_line_len_odd, .o_line_len_cur, .o_vout_group_onehot, .o_group_len_eff);

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	// stimulus and observed signals
	logic        i_ref_clk, i_sys_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [7:0]  i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata, q;
	logic        i_seq_change_update = 1'b0, i_line_is_odd = 1'b0, e;
	logic [3:0]  i_last_repetition = 4'hF;
	logic [51:0] i_pattern_len_grp = {13'h0444, 13'h0333, 13'h0222, 13'h0111};
	logic        o_pready, o_pslverr, o_horiz_blank_normal, o_horiz_blank_mode1;
	logic        o_substrate_clk_mask_en;
	logic [1:0]  o_horiz_blank_mode_sel;
	logic [13:0] o_line_len_even, o_line_len_odd, o_line_len_cur;
	logic [23:0] o_gate_toggle_pair_sel, o_vout_start_polarity;
	logic [47:0] o_vout_group_onehot;
	logic [51:0] o_group_len_eff;
	int          fails = 0, cmp_count = 0;
	// address, written word, expected read-back; control word keeps test bits and code 11 out
	logic [7:0]  adr_t [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h00};
	logic [31:0] wd_t [8] = '{32'hFFFF1234, 32'h2ABC, 32'hFFA5A5A5, 32'hFEAAAAAA,
		32'h3FFE123, 32'h5A5A5A, 32'hE4E4E4, 32'h1150000};
	logic [31:0] rb_t [8] = '{32'h1234, 32'h2ABC, 32'hA5A5A5, 32'h2AAAAAA,
		32'h3FFE123, 32'h5A5A5A, 32'hE4E4E4, 32'h1150000};
	vsq_config_regs uut (.i_ref_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_seq_change_update, .i_line_is_odd,
		.i_last_repetition, .i_pattern_len_grp, .o_horiz_blank_mode_sel, .o_horiz_blank_normal,
		.o_horiz_blank_mode1, .o_substrate_clk_mask_en, .o_line_len_even, .o_line_len_odd,
		.o_line_len_cur, .o_gate_toggle_pair_sel, .o_vout_start_polarity,
		.o_vout_group_onehot, .o_group_len_eff);
	initial
	begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
		cmp_count++;
		if (g !== x)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	// idle cycle first, so no strobe is assigned twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rq, output logic re);
		@(posedge i_ref_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		// answer is taken at the edge that sees pready high; only the watchdog ends a hang
		do
			@(posedge i_ref_clk);
		while (o_pready !== 1'b1);
		rq = o_prdata;
		re = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, q, e);
		chk($sformatf("reg %h", a), x, q);
	endtask : rd
	task automatic upd;
		@(posedge i_ref_clk);
		i_seq_change_update <= 1'b1;
		@(posedge i_ref_clk);
		i_seq_change_update <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
	endtask : upd
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		for (int i = 0; i < 8; i++)
			rd(adr_t[i], 32'h0);
		for (int i = 0; i < 8; i++)
			apb(1'b1, adr_t[i], wd_t[i], q, e);
		for (int i = 0; i < 8; i++)
			rd(adr_t[i], rb_t[i]);
		rd(8'h7C, 32'h1);
		@(negedge i_ref_clk);
		chk("mask staged", 0, o_substrate_clk_mask_en);
		upd;
		chk("mask", 1, o_substrate_clk_mask_en);
		chk("even", 14'h1234, o_line_len_even);
		chk("odd", 14'h2ABC, o_line_len_odd);
		chk("toggle", 24'hA5A5A5, o_gate_toggle_pair_sel);
		chk("polarity", 24'h5A5A5A, o_vout_start_polarity);
		chk("group", 48'h842184218421, o_vout_group_onehot);
		chk("mode1", 1, o_horiz_blank_mode1);
		chk("final", {13'h0444, 13'h0123, 13'h0222, 13'h0AAA}, o_group_len_eff);
		chk("mode sel", 2'h1, o_horiz_blank_mode_sel);
		rd(8'h7C, 32'h0);
	endtask : t_regs
	task automatic t_len;
		@(posedge i_ref_clk);
		i_last_repetition <= 4'h0;
		i_line_is_odd <= 1'b1;
		@(posedge i_ref_clk);
		@(negedge i_ref_clk);
		chk("normal", i_pattern_len_grp, o_group_len_eff);
		chk("odd cur", 14'h2ABC, o_line_len_cur);
		@(posedge i_ref_clk);
		i_line_is_odd <= 1'b0;
		@(posedge i_ref_clk);
		@(negedge i_ref_clk);
		chk("even cur", 14'h1234, o_line_len_cur);
	endtask : t_len
	task automatic t_blank;
		apb(1'b1, 8'h00, 32'h0, q, e);
		i_last_repetition <= 4'hF;
		upd;
		chk("normal", 1, o_horiz_blank_normal);
		chk("mask off", 0, o_substrate_clk_mask_en);
		chk("no final", i_pattern_len_grp, o_group_len_eff);
	endtask : t_blank
	task automatic t_refuse;
		apb(1'b1, 8'h20, 32'hFFFFFFFF, q, e);
		chk("unmapped err", 1, e);
		rd(8'h20, 32'h0);
		rd(8'h00, 32'h0);
	endtask : t_refuse
	// final lengths equal to the normal lengths, all groups enabled, last repetition active
	task automatic t_equal;
		apb(1'b1, 8'h10, {6'h00, 13'h0222, 13'h0111}, q, e);
		apb(1'b1, 8'h14, {6'h00, 13'h0444, 13'h0333}, q, e);
		apb(1'b1, 8'h00, 32'h000F0000, q, e);
		upd;
		chk("equal final", i_pattern_len_grp, o_group_len_eff);
	endtask : t_equal
	// main sequence and watchdog
	initial
	begin
		repeat (12) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		t_regs;
		t_len;
		t_blank;
		t_refuse;
		t_equal;
		final_report;
	end
	initial
	begin
		repeat (5000) @(posedge i_ref_clk);
		fails++;
		final_report;
	end
endmodule : tb_top
